// ==== verilog/mcr_config_regs.sv ====
/*
 * metering configuration register bank: computation mode and channel
 * gain registers with their decoded controls, the nominal voltage
 * substitution for apparent power and the per-output phase summing with
 * a digital-to-frequency converter for the three pulse outputs.
 * assumes per-phase power samples, rms voltages and the nominal voltage
 * come from logic on clk; the host port follows the plain strobe protocol.
 */
// Our own choice: the strobed register port.
//
// Contract
// - bits 0..2 of computation mode put phase a, b, c into the first pulse output sum, each resetting to 1.
// - bits 3..5 put phase a, b, c into the second pulse output sum, each resetting to 1.
// - bits 6..8 put phase a, b, c into the third pulse output sum, each resetting to 1.
// - bits 10:9 pick volt-current, volt-volt, current-current or no angle measurement, resetting to 00.
// - bits 11..13 make phase a, b, c apparent power use the nominal voltage instead of rms, resetting to 0.
// - bit 15 of computation mode resets to 0 and controls nothing.
// - gain bits 2:0 pick phase current gain 1,2,4,8,16 for codes 0..4, codes 5..7 acting as 0, reset 0.
// - gain bits 5:3 pick neutral current gain the same way, codes 5..7 acting as 0, reset 0.
// - gain bits 8:6 pick phase voltage gain the same way, codes 5..7 acting as 0, reset 0.
// - gain bits 15:9 reset to zero and control nothing.
// - each pulse output rate follows the magnitude of the sum of the chosen power over its enabled phases.
`timescale 1ns/100ps

module mcr_config_regs #(
	parameter int PWR_W = 24,
	parameter int NOMINAL_VOLTAGE_VALUE_W = 24,
	parameter int ACC_W = 32
) (
	clk,
	rst_n,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	phase_power,
	rms_voltage,
	nominal_voltage_value,
	mode_cfg,
	gain_eff,
	angle_en,
	line_freq_select,
	apparent_voltage,
	pulse_sum,
	pulse_out_1,
	pulse_out_2,
	pulse_out_3
);
	input wire logic clk;
	input wire logic rst_n;
	input wire logic [15:0] reg_addr;
	input wire logic [15:0] reg_wdata;
	input wire logic reg_wr;
	input wire logic reg_rd;
	output logic [15:0] reg_rdata;
	input wire logic [2:0][2:0][PWR_W-1:0] phase_power;
	input wire logic [2:0][NOMINAL_VOLTAGE_VALUE_W-1:0] rms_voltage;
	input wire logic [NOMINAL_VOLTAGE_VALUE_W-1:0] nominal_voltage_value;
	output mcr_pkg::mcr_cmode_type mode_cfg;
	output mcr_pkg::mcr_gain_eff_type gain_eff;
	output mcr_pkg::mcr_angle_en_type angle_en;
	output logic line_freq_select;
	output logic [2:0][NOMINAL_VOLTAGE_VALUE_W-1:0] apparent_voltage;
	output logic [2:0][PWR_W+1:0] pulse_sum;
	output logic pulse_out_1;
	output logic pulse_out_2;
	output logic pulse_out_3;

	localparam int SUM_W = PWR_W + 2;

	// refuse widths the converter cannot serve
	generate
		if (PWR_W < 2 || NOMINAL_VOLTAGE_VALUE_W < 1 || ACC_W < SUM_W) begin : g_bad_width
			$error("mcr_config_regs: need PWR_W >= 2, NOMINAL_VOLTAGE_VALUE_W >= 1 and ACC_W >= PWR_W + 2");
		end
	endgenerate

	// whole state of the block
	typedef struct packed {
		mcr_pkg::mcr_cmode_type cmode;
		mcr_pkg::mcr_gain_type gain;
		logic [15:0] rdata;
		mcr_pkg::mcr_gain_eff_type gain_eff;
		mcr_pkg::mcr_angle_en_type angle_en;
		logic [2:0][NOMINAL_VOLTAGE_VALUE_W-1:0] app_volt;
		logic [2:0][SUM_W-1:0] sum;
		logic [2:0][ACC_W-1:0] acc;
		logic [2:0] pulse;
	} mcr_state_type;

	mcr_state_type state_q;
	mcr_state_type state_d;

	// reserved gain codes fall back to unity
	function automatic logic [2:0] mcr_gain_code(input logic [2:0] code);
		logic [2:0] eff;
		eff = (code > mcr_pkg::GAIN_CODE_MAX) ? mcr_pkg::GAIN_CODE_UNITY : code;
		return eff;
	endfunction

	// phase-included sum of one output's power samples
	function automatic logic [SUM_W-1:0] mcr_phase_sum(input logic [2:0] phase_en,
			input logic [2:0][PWR_W-1:0] power);
		logic signed [SUM_W-1:0] total;
		total = '0;
		for (int p = 0; p < 3; p++) begin
			if (phase_en[p]) begin
				total = total + SUM_W'($signed(power[p]));
			end
		end
		return total;
	endfunction

	// magnitude of a signed sum, for the frequency converter
	function automatic logic [SUM_W-1:0] mcr_magnitude(input logic [SUM_W-1:0] value);
		logic [SUM_W-1:0] mag;
		mag = value[SUM_W-1] ? SUM_W'(-$signed(value)) : value;
		return mag;
	endfunction

	// next-state logic: register port, decoders and pulse datapath
	always_comb begin
		logic [2:0] phase_en;
		logic [ACC_W:0] acc_next;
		logic [SUM_W-1:0] mag;
		phase_en = '0;
		acc_next = '0;
		mag = '0;
		state_d = state_q;

		// host writes; reserved bits never take a one
		if (reg_wr && reg_addr == mcr_pkg::COMPUTATION_MODE_OFFSET) begin
			state_d.cmode = mcr_pkg::mcr_cmode_type'(reg_wdata & mcr_pkg::COMPUTATION_MODE_MASK);
		end
		if (reg_wr && reg_addr == mcr_pkg::CHANNEL_GAIN_SELECT_OFFSET) begin
			state_d.gain = mcr_pkg::mcr_gain_type'(reg_wdata & mcr_pkg::CHANNEL_GAIN_SELECT_MASK);
		end

		// host reads: data in the following cycle, unmapped reads zero
		state_d.rdata = '0;
		if (reg_rd) begin
			if (reg_addr == mcr_pkg::COMPUTATION_MODE_OFFSET) begin
				state_d.rdata = 16'(state_q.cmode) & mcr_pkg::COMPUTATION_MODE_MASK;
			end else if (reg_addr == mcr_pkg::CHANNEL_GAIN_SELECT_OFFSET) begin
				state_d.rdata = 16'(state_q.gain) & mcr_pkg::CHANNEL_GAIN_SELECT_MASK;
			end
		end

		// effective gain codes for the three channel groups
		state_d.gain_eff.phase_current_gain = mcr_gain_code(state_q.gain.phase_current_gain);
		state_d.gain_eff.neutral_current_gain = mcr_gain_code(state_q.gain.neutral_current_gain);
		state_d.gain_eff.phase_voltage_gain = mcr_gain_code(state_q.gain.phase_voltage_gain);

		// angle measurement pair decode
		state_d.angle_en = '0;
		unique case (state_q.cmode.angle_pair_select)
			mcr_pkg::ANGLE_VOLT_CURR: state_d.angle_en.volt_curr = 1'b1;
			mcr_pkg::ANGLE_VOLT_VOLT: state_d.angle_en.volt_volt = 1'b1;
			mcr_pkg::ANGLE_CURR_CURR: state_d.angle_en.curr_curr = 1'b1;
			mcr_pkg::ANGLE_NONE: state_d.angle_en = '0;
		endcase

		// voltage used for apparent power, per phase
		for (int p = 0; p < 3; p++) begin
			state_d.app_volt[p] = state_q.cmode.nominal_volt_use[p] ? nominal_voltage_value : rms_voltage[p];
		end

		// per-output phase sums and frequency conversion
		for (int k = 0; k < 3; k++) begin
			unique case (k)
				0: phase_en = state_q.cmode.pulse1_phase_include;
				1: phase_en = state_q.cmode.pulse2_phase_include;
				default: phase_en = state_q.cmode.pulse3_phase_include;
			endcase
			state_d.sum[k] = mcr_phase_sum(phase_en, phase_power[k]);
			mag = mcr_magnitude(state_q.sum[k]);
			acc_next = {1'b0, state_q.acc[k]} + (ACC_W+1)'(mag);
			state_d.acc[k] = acc_next[ACC_W-1:0];
			state_d.pulse[k] = acc_next[ACC_W];
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q.cmode <= mcr_pkg::mcr_cmode_type'(mcr_pkg::COMPUTATION_MODE_RESET);
			state_q.gain <= mcr_pkg::mcr_gain_type'(mcr_pkg::CHANNEL_GAIN_SELECT_RESET);
			state_q.rdata <= '0;
			state_q.gain_eff <= '0;
			state_q.angle_en <= 3'h1; // volt-current pair after reset
			state_q.app_volt <= '0;
			state_q.sum <= '0;
			state_q.acc <= '0;
			state_q.pulse <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// outputs straight from the state register
	assign reg_rdata = state_q.rdata;
	assign mode_cfg = state_q.cmode;
	assign gain_eff = state_q.gain_eff;
	assign angle_en = state_q.angle_en;
	assign line_freq_select = state_q.cmode.line_freq_select;
	assign apparent_voltage = state_q.app_volt;
	assign pulse_sum = state_q.sum;
	assign pulse_out_1 = state_q.pulse[0];
	assign pulse_out_2 = state_q.pulse[1];
	assign pulse_out_3 = state_q.pulse[2];

endmodule

// ==== verilog/mcr_pkg.sv ====
/*
 * constants, field layouts and carrier types of the metering
 * configuration register bank (computation mode and channel gain).
 * assumes a 16-bit register port addressed by the printed offsets.
 */
package mcr_pkg;

	// register offsets on the host port
	localparam logic [15:0] COMPUTATION_MODE_OFFSET = 16'hE60E;
	localparam logic [15:0] CHANNEL_GAIN_SELECT_OFFSET = 16'hE60F;

	// reset values
	localparam logic [15:0] COMPUTATION_MODE_RESET = 16'h01FF;
	localparam logic [15:0] CHANNEL_GAIN_SELECT_RESET = 16'h0000;

	// bits that hold state; the rest read as zero
	localparam logic [15:0] COMPUTATION_MODE_MASK = 16'h7FFF;
	localparam logic [15:0] CHANNEL_GAIN_SELECT_MASK = 16'h01FF;

	// highest gain code that selects a real gain (x16)
	localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
	localparam logic [2:0] GAIN_CODE_UNITY = 3'h0;

	// angle measurement pair codes
	typedef enum logic [1:0] {
		ANGLE_VOLT_CURR = 2'h0,
		ANGLE_VOLT_VOLT = 2'h1,
		ANGLE_CURR_CURR = 2'h2,
		ANGLE_NONE = 2'h3
	} mcr_angle_code_type;

	// computation mode register, msb first
	typedef struct packed {
		logic spare;
		logic line_freq_select;
		logic [2:0] nominal_volt_use;
		mcr_angle_code_type angle_pair_select;
		logic [2:0] pulse3_phase_include;
		logic [2:0] pulse2_phase_include;
		logic [2:0] pulse1_phase_include;
	} mcr_cmode_type;

	// channel gain select register, msb first
	typedef struct packed {
		logic [6:0] spare;
		logic [2:0] phase_voltage_gain;
		logic [2:0] neutral_current_gain;
		logic [2:0] phase_current_gain;
	} mcr_gain_type;

	// effective gain codes seen by the front end (0..4 = x1..x16)
	typedef struct packed {
		logic [2:0] phase_voltage_gain;
		logic [2:0] neutral_current_gain;
		logic [2:0] phase_current_gain;
	} mcr_gain_eff_type;

	// angle measurement enables, at most one set
	typedef struct packed {
		logic curr_curr;
		logic volt_volt;
		logic volt_curr;
	} mcr_angle_en_type;

endpackage

// ==== bench/mcr_config_regs_props.sv ====
/* config bank checker: register port and decoded controls; bound to every mcr_config_regs. */
`timescale 1ns/100ps
module mcr_config_regs_props #(parameter int PWR_W = 24) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [2:0][2:0][PWR_W-1:0] phase_power,
	input wire mcr_pkg::mcr_cmode_type mode_cfg,
	input wire mcr_pkg::mcr_gain_eff_type gain_eff,
	input wire mcr_pkg::mcr_angle_en_type angle_en,
	input wire logic [2:0][PWR_W+1:0] pulse_sum
);
	localparam logic [15:0] CMO = mcr_pkg::COMPUTATION_MODE_OFFSET;
	localparam logic [15:0] GSO = mcr_pkg::CHANNEL_GAIN_SELECT_OFFSET;
	logic signed [PWR_W+1:0] exp_sum [3];
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// signed sum of the included phases per output
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			exp_sum[k] = '0;
			for (int p = 0; p < 3; p++)
				if (mode_cfg[3 * k + p])
					exp_sum[k] += signed'(phase_power[k][p]);
		end
	end
	// reserved gain codes fall back to unity
	function automatic logic [2:0] eff(logic [2:0] c);
		return c > 3'h4 ? 3'h0 : c;
	endfunction
	sequence gain_wr;
		reg_wr && reg_addr == GSO ##1 !(reg_wr && reg_addr == GSO);
	endsequence
	AST_MODE_WR: assert property (
		reg_wr && reg_addr == CMO |=> mode_cfg == ($past(reg_wdata) & 16'h7FFF)) else $error("mode write lost");
	AST_SPARE: assert property (!mode_cfg.spare) else $error("spare bit set");
	AST_ANGLE: assert property ($past(rst_n) |-> angle_en == {$past(mode_cfg[10:9]) == 2'h2,
		$past(mode_cfg[10:9]) == 2'h1, $past(mode_cfg[10:9]) == 2'h0}) else $error("angle enables wrong");
	AST_RD_MODE: assert property (reg_rd && reg_addr == CMO |=> reg_rdata == $past(mode_cfg))
		else $error("mode read wrong");
	AST_RD_GAIN: assert property (reg_rd && reg_addr == GSO |=> reg_rdata[15:9] == 7'h00)
		else $error("gain spare read set");
	AST_RD_NONE: assert property (!reg_rd || reg_addr != CMO && reg_addr != GSO |=> reg_rdata == 16'h0000)
		else $error("idle read data set");
	AST_GAIN_EFF: assert property (gain_wr |=> gain_eff == {eff($past(reg_wdata[8:6], 2)),
		eff($past(reg_wdata[5:3], 2)), eff($past(reg_wdata[2:0], 2))}) else $error("gain codes wrong");
	// per-output sums one cycle behind their inputs
	for (genvar i = 0; i < 3; i++) begin : g_out
		AST_SUM: assert property ($past(rst_n) |-> pulse_sum[i] == $past(exp_sum[i]))
			else $error("pulse sum wrong");
	end
endmodule
bind mcr_config_regs mcr_config_regs_props #(.PWR_W(PWR_W)) i_props (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.phase_power(phase_power), .mode_cfg(mode_cfg), .gain_eff(gain_eff), .angle_en(angle_en),
	.pulse_sum(pulse_sum));

// ==== bench/testbench.sv ====
/* random register traffic against an integer model; checker bound alongside. */
`timescale 1ns/100ps
module testbench;
	localparam logic [15:0] CMO = mcr_pkg::COMPUTATION_MODE_OFFSET;
	localparam logic [15:0] GSO = mcr_pkg::CHANNEL_GAIN_SELECT_OFFSET;
	logic clk = 0;
	logic rst_n = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [15:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0;
	logic [15:0] reg_rdata;
	logic [2:0][2:0][23:0] pp = '0;
	logic [2:0][23:0] rv = '0;
	logic [23:0] nv = '0;
	logic [2:0][23:0] av;
	logic lfs;
	mcr_pkg::mcr_cmode_type mode;
	mcr_pkg::mcr_gain_eff_type ge;
	int n_errors = 0;
	int num_checks = 0;
	int m_mode;
	int m_gain;
	mcr_config_regs i_mcr_config_regs (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_power(pp), .rms_voltage(rv),
		.nominal_voltage_value(nv), .mode_cfg(mode), .gain_eff(ge), .angle_en(), .line_freq_select(lfs),
		.apparent_voltage(av), .pulse_sum(), .pulse_out_1(), .pulse_out_2(), .pulse_out_3());
	// one strobe cycle, held to the next rising edge
	task automatic bus(bit w, logic [15:0] a, logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge clk);
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// read back, data stands one cycle after the strobe
	task automatic rdchk(logic [15:0] a);
		bus(0, a, 16'h0000);
		reg_rd <= 0;
		#1 chk("reg_rdata", a == CMO ? m_mode : a == GSO ? m_gain : 0, reg_rdata);
	endtask
	function automatic int eff(int c);
		return c > 4 ? 0 : c;
	endfunction
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial forever #4 clk = ~clk;
	// two passes: power-up reset, then a reset in mid-run
	initial begin
		logic [15:0] a;
		logic [15:0] d;
		void'($urandom(72));
		for (int r = 0; r < 2; r++) begin
			@(posedge clk);
			rst_n <= 0;
			repeat (3) @(posedge clk);
			rst_n <= 1;
			@(posedge clk);
			m_mode = 16'h01FF;
			m_gain = 0;
			rdchk(CMO);
			rdchk(GSO);
			for (int i = 0; i < 300; i++) begin
				a = $urandom % 3 == 0 ? 16'($urandom) : $urandom % 2 ? CMO : GSO;
				d = 16'($urandom);
				for (int j = 0; j < 9; j++)
					pp[j / 3][j % 3] <= 24'($urandom);
				for (int p = 0; p < 3; p++)
					rv[p] <= 24'($urandom);
				nv <= 24'($urandom);
				bus(1, a, d);
				if (a == CMO)
					m_mode = d & 16'h7FFF;
				if (a == GSO)
					m_gain = d & 16'h01FF;
				rdchk(a);
				@(posedge clk);
				#1 chk("gain_eff", eff(m_gain >> 6 & 7) << 6 | eff(m_gain >> 3 & 7) << 3 | eff(m_gain & 7), 16'(ge));
				chk("mode_cfg", m_mode, mode);
				chk("line_freq_select", m_mode >> 14 & 1, lfs);
				for (int p = 0; p < 3; p++)
					chk("apparent_voltage", m_mode >> (11 + p) & 1 ? nv : rv[p], av[p]);
			end
		end
		give_verdict;
	end
endmodule
